// File: csws_regs.svh
// Constants of the processor speed and wait-state controller.
// Assumes inclusion by bare name from the module, the checker and the bench.
`ifndef CSWS_REGS_SVH
`define CSWS_REGS_SVH

// -----------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------
`define CSWS_CTRL_OFF 8'h00
`define CSWS_STAT_OFF 8'h04
`define CSWS_CTRL_CPU_RST 0
`define CSWS_CTRL_NPX_RST 1
`define CSWS_CTRL_OBW_LSB 2
`define CSWS_CTRL_OBW_MSB 4
`define CSWS_OBW_RST 3'h4
`define CSWS_STAT_FAST 0
`define CSWS_STAT_EFI 1
`define CSWS_STAT_CPU_RST 2
`define CSWS_STAT_NPX_RST 3
`define CSWS_STAT_HOLD_ACKNOWLEDGE 4
`define CSWS_STAT_WS_LSB 8

// -----------------------------------------------------------------------
// Wait-state counts
// -----------------------------------------------------------------------
`define CSWS_WS_ZERO 4'h0
`define CSWS_WS_SYSMEM 4'h1
`define CSWS_WS_SLOW8 4'h4
`define CSWS_WS_SLOW16 4'h1
`define CSWS_WS_FAST8MEM 4'h6
`define CSWS_WS_FAST8IO 4'h4
`define CSWS_WS_FAST16MEM 4'h1
`define CSWS_WS_FAST16IO 4'h2
`define CSWS_OBW_MIN 3'h1
`define CSWS_OBW_MAX 3'h4
`define CSWS_WS_CHAIN 10

// -----------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------
`define CSWS_CLK_MHZ 125
`define CSWS_FAST_MHZ 8
`define CSWS_SLOW_MHZ 6
`define CSWS_RST_STRETCH 16

`endif

// File: csws_pkg.sv
// Types shared by the processor speed and wait-state controller.
// Assumes csws_regs.svh is on the include path.
package csws_pkg;
  typedef enum logic [2:0] {
    CSWS_IDLE,
    CSWS_DLY,
    CSWS_CMD,
    CSWS_DONE
  } csws_bus_t;
  typedef logic [3:0] csws_ws_t;
endpackage

// File: csws_top.sv
// Processor speed select, reset distribution, bus command and wait-state logic.
// Assumes one 125 MHz clock, a synchronous reset and a classic Wishbone master.
//
// Function
// [R01] Faster speed is the default after configuration.
// [R02] Switch open: rear switch picks oscillator, 8 MHz.
// [R03] Switch closed: crystal, rear ignored, 6 MHz.
// [R04] Ready goes low when bus cycle completes.
// [R05] One power-up reset feeds processor and coprocessor.
// [R06] Software reset returns processor to real mode.
// [R07] Processor resets coprocessor after execution error.
// [R08] Bus control takes clock, ready, status, terminate, delay.
// [R09] Generates strobes, acknowledge, enable, latch, select, hold.
// [R10] Each wait-state adds one clock to cycle.
// [R11] On-board devices get one to four waits.
// [R12] Slow channel: 8-bit four, 16-bit one wait.
// [R13] Fast channel: 8-bit six, 16-bit mem one, I/O two.
// [R14] Flip-flop chain counts waits, drives command terminate.
// [R15] Zero-wait request removes all wait-states; the code honours it for off-board memory cycles only.
// [R16] System memory cycles get exactly one wait.
// [R17] Normal 8-bit I/O gets four generated waits.
// [R18] Counter loads at strobe, terminates at zero.
// [R19] Waits decoded from speed, select, width, location.
//
// The Wishbone register port and the register offsets were left to the implementer.
`include "csws_regs.svh"

module csws_top
  import csws_pkg::*;
#(
  parameter int CHAIN = `CSWS_WS_CHAIN
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Switches and power-on pins
  input wire logic config_switch_bank_i,
  input wire logic rear_speed_switch_i,
  input wire logic power_good_i,
  // Processor status and target attributes
  input wire logic cpu_status_bit_low_i,
  input wire logic cpu_status_bit_high_i,
  input wire logic mem_io_i,
  input wire logic on_board_i,
  input wire logic width16_i,
  input wire logic zero_wait_request_n_i,
  input wire logic command_delay_i,
  input wire logic hold_request_i,
  // Clock and reset outputs
  output logic external_freq_input_o,
  output logic cpu_fast_o,
  output logic system_clock_n_o,
  output logic cpu_reset_o,
  output logic npx_reset_o,
  // Bus command outputs
  output logic ready_n_o,
  output logic command_terminate_o,
  output logic ale_o,
  output logic mem_rd_n_o,
  output logic mem_wr_n_o,
  output logic io_rd_n_o,
  output logic io_wr_n_o,
  output logic interrupt_acknowledge_n_o,
  output logic data_enable_strobe_o,
  output logic mem_io_sel_o,
  output logic hold_acknowledge_o
);

  // ---------------------------------------------------------------------
  // Constants
  // ---------------------------------------------------------------------
  localparam logic [4:0] DIV_FAST = 5'(`CSWS_CLK_MHZ / `CSWS_FAST_MHZ);
  localparam logic [4:0] DIV_SLOW = 5'(`CSWS_CLK_MHZ / `CSWS_SLOW_MHZ);
  localparam logic [4:0] STRETCH = 5'(`CSWS_RST_STRETCH);

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  // Bit order: cfg, rear, pgood, s0, s1, mio, onb, w16, zws_n, command_delay, hold.
  localparam int NPIN = 11;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] meta_q;
  logic [NPIN-1:0] sync_q;
  assign pin_raw = {hold_request_i, command_delay_i, zero_wait_request_n_i,
                    width16_i, on_board_i, mem_io_i, cpu_status_bit_high_i,
                    cpu_status_bit_low_i, power_good_i, rear_speed_switch_i,
                    config_switch_bank_i};

  // Switches reset to open so the faster speed holds until they are seen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 11'h006;
      sync_q <= 11'h006;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
    end
  end

  logic cfg_closed;
  logic rear_open;
  logic pgood;
  logic [1:0] status;
  logic mio;
  logic onb;
  logic w16;
  logic zws;
  logic command_delay;
  logic hreq;
  assign cfg_closed = sync_q[0];
  assign rear_open = sync_q[1];
  assign pgood = sync_q[2];
  assign status = {sync_q[4], sync_q[3]};
  assign mio = sync_q[5];
  assign onb = sync_q[6];
  assign w16 = sync_q[7];
  assign zws = ~sync_q[8];
  assign command_delay = sync_q[9];
  assign hreq = sync_q[10];

  // ---------------------------------------------------------------------
  // Speed select and system clock divider
  // ---------------------------------------------------------------------
  logic fast_d;
  assign fast_d = ~cfg_closed & rear_open; // [R01] [R02] [R03]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_fast_o <= 1'b1;
      external_freq_input_o <= 1'b1;
    end else begin
      cpu_fast_o <= fast_d; // [R01]
      external_freq_input_o <= fast_d; // [R02]
    end
  end

  logic [4:0] div_q;
  logic tick_q;
  logic [4:0] div_max;
  assign div_max = cpu_fast_o ? DIV_FAST - 5'h01 : DIV_SLOW - 5'h01; // [R02] [R03]

  // The tick is the rising edge of the system clock; the pin is its inverse.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= 5'h00;
      tick_q <= 1'b0;
      system_clock_n_o <= 1'b1;
    end else begin
      tick_q <= (div_q >= div_max);
      div_q <= (div_q >= div_max) ? 5'h00 : div_q + 5'h01;
      system_clock_n_o <= (div_q < {1'b0, div_max[4:1]}) ? 1'b0 : 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------
  logic wb_req;
  logic wr_ctrl;
  logic [2:0] obw_q;
  logic sw_cpu_rst;
  logic sw_npx_rst;
  csws_ws_t ws_last_q;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_ctrl = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `CSWS_CTRL_OFF);
  assign sw_cpu_rst = wr_ctrl & wb_dat_i[`CSWS_CTRL_CPU_RST];
  assign sw_npx_rst = wr_ctrl & wb_dat_i[`CSWS_CTRL_NPX_RST];

  // Out-of-range on-board counts are clamped so a bad write cannot stall I/O.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      obw_q <= `CSWS_OBW_RST;
    end else if (wr_ctrl) begin
      if (wb_dat_i[`CSWS_CTRL_OBW_MSB:`CSWS_CTRL_OBW_LSB] < `CSWS_OBW_MIN) begin
        obw_q <= `CSWS_OBW_MIN; // [R11]
      end else if (wb_dat_i[`CSWS_CTRL_OBW_MSB:`CSWS_CTRL_OBW_LSB] > `CSWS_OBW_MAX) begin
        obw_q <= `CSWS_OBW_MAX; // [R11]
      end else begin
        obw_q <= wb_dat_i[`CSWS_CTRL_OBW_MSB:`CSWS_CTRL_OBW_LSB];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i && wb_adr_i == `CSWS_CTRL_OFF) begin
        wb_dat_o <= {27'h0000000, obw_q, 2'h0};
      end else if (wb_req && !wb_we_i && wb_adr_i == `CSWS_STAT_OFF) begin
        wb_dat_o <= {20'h00000, ws_last_q, 3'h0, hold_acknowledge_o,
                     npx_reset_o, cpu_reset_o, external_freq_input_o, cpu_fast_o};
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Reset distribution
  // ---------------------------------------------------------------------
  logic shutdown;
  logic [4:0] cpu_cnt_q;
  logic [4:0] npx_cnt_q;
  csws_bus_t state_q;

  // Shutdown is the halt encoding with memory selected; the processor needs
  // a stretched reset to leave it, the same path software uses.
  assign shutdown = tick_q & (state_q == CSWS_IDLE) & (status == 2'h0) & mio;

  always_ff @(posedge clk_i) begin
    if (rst_i || !pgood) begin
      cpu_cnt_q <= STRETCH; // [R05]
    end else if (sw_cpu_rst || shutdown) begin
      cpu_cnt_q <= STRETCH; // [R06]
    end else if (cpu_cnt_q != 5'h00) begin
      cpu_cnt_q <= cpu_cnt_q - 5'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !pgood) begin
      npx_cnt_q <= STRETCH; // [R05]
    end else if (sw_npx_rst) begin
      npx_cnt_q <= STRETCH; // [R07]
    end else if (npx_cnt_q != 5'h00) begin
      npx_cnt_q <= npx_cnt_q - 5'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_reset_o <= 1'b1;
      npx_reset_o <= 1'b1;
    end else begin
      cpu_reset_o <= (cpu_cnt_q != 5'h00); // [R05] [R06]
      npx_reset_o <= (npx_cnt_q != 5'h00); // [R05]
    end
  end

  // ---------------------------------------------------------------------
  // Wait-state selection
  // ---------------------------------------------------------------------
  csws_ws_t ws_sel;
  always_comb begin
    if (onb) begin
      ws_sel = mio ? `CSWS_WS_SYSMEM : {1'b0, obw_q}; // [R11] [R16]
    end else if (zws && mio) begin
      ws_sel = `CSWS_WS_ZERO; // [R15]
    end else if (!cpu_fast_o) begin
      ws_sel = w16 ? `CSWS_WS_SLOW16 : `CSWS_WS_SLOW8; // [R12]
    end else if (w16) begin
      ws_sel = mio ? `CSWS_WS_FAST16MEM : `CSWS_WS_FAST16IO; // [R13]
    end else begin
      ws_sel = mio ? `CSWS_WS_FAST8MEM : `CSWS_WS_FAST8IO; // [R13] [R17] [R19]
    end
  end

  // ---------------------------------------------------------------------
  // Bus command sequencer
  // ---------------------------------------------------------------------
  logic start;
  logic load;
  logic [CHAIN-1:0] chain_q;
  logic rd_q;
  logic wr_q;
  logic interrupt_acknowledge_q;
  logic mio_q;

  assign start = tick_q & (state_q == CSWS_IDLE) & (status != 2'h3) & ~cpu_reset_o
                 & ~hold_acknowledge_o & ~(status == 2'h0 && mio);
  assign load = tick_q & (state_q == CSWS_DLY) & ~command_delay;

  always_ff @(posedge clk_i) begin
    if (rst_i || cpu_reset_o) begin
      state_q <= CSWS_IDLE;
    end else if (tick_q) begin
      case (state_q)
        CSWS_IDLE: if (start) begin
          state_q <= CSWS_DLY;
        end
        CSWS_DLY: if (!command_delay) begin
          state_q <= CSWS_CMD; // [R08]
        end
        CSWS_CMD: if (!chain_q[0]) begin
          state_q <= CSWS_DONE; // [R10]
        end
        CSWS_DONE: state_q <= CSWS_IDLE;
        default: state_q <= CSWS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      interrupt_acknowledge_q <= 1'b0;
      mio_q <= 1'b0;
    end else if (start) begin
      rd_q <= (status == 2'h1);
      wr_q <= (status == 2'h2);
      interrupt_acknowledge_q <= (status == 2'h0);
      mio_q <= mio;
    end
  end

  // One flip-flop per wait; the loaded run of ones drains one per system clock tick.
  for (genvar i = 0; i < CHAIN; i++) begin : g_chain
    always_ff @(posedge clk_i) begin
      if (rst_i || cpu_reset_o) begin
        chain_q[i] <= 1'b0;
      end else if (load) begin
        chain_q[i] <= (i < int'(ws_sel)); // [R14] [R18]
      end else if (tick_q && state_q == CSWS_CMD) begin
        chain_q[i] <= (i == CHAIN - 1) ? 1'b0 : chain_q[(i + 1) % CHAIN]; // [R14]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ws_last_q <= `CSWS_WS_ZERO;
    end else if (load) begin
      ws_last_q <= ws_sel;
    end
  end

  logic cmd_act;
  logic term;
  assign term = tick_q & (state_q == CSWS_CMD) & ~chain_q[0];
  assign cmd_act = (state_q == CSWS_CMD) & ~term;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ale_o <= 1'b0;
      command_terminate_o <= 1'b0;
      ready_n_o <= 1'b1;
      mem_rd_n_o <= 1'b1;
      mem_wr_n_o <= 1'b1;
      io_rd_n_o <= 1'b1;
      io_wr_n_o <= 1'b1;
      interrupt_acknowledge_n_o <= 1'b1;
      data_enable_strobe_o <= 1'b0;
      mem_io_sel_o <= 1'b0;
    end else begin
      ale_o <= (state_q == CSWS_DLY) & ~cpu_reset_o; // [R09]
      command_terminate_o <= term; // [R14] [R18]
      // Ready is held for the whole final system clock period.
      ready_n_o <= ~((state_q == CSWS_DONE) | term); // [R04]
      mem_rd_n_o <= ~(cmd_act & rd_q & mio_q); // [R09]
      mem_wr_n_o <= ~(cmd_act & wr_q & mio_q); // [R09]
      io_rd_n_o <= ~(cmd_act & rd_q & ~mio_q); // [R09]
      io_wr_n_o <= ~(cmd_act & wr_q & ~mio_q); // [R09]
      interrupt_acknowledge_n_o <= ~(cmd_act & interrupt_acknowledge_q); // [R09]
      data_enable_strobe_o <= cmd_act; // [R09]
      mem_io_sel_o <= mio_q; // [R09]
    end
  end

  // ---------------------------------------------------------------------
  // Hold handshake toward DMA
  // ---------------------------------------------------------------------
  // Hold is granted only between cycles so a command is never cut short.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_acknowledge_o <= 1'b0;
    end else if (!hreq) begin
      hold_acknowledge_o <= 1'b0;
    end else if (state_q == CSWS_IDLE && !start) begin
      hold_acknowledge_o <= 1'b1; // [R09]
    end
  end

endmodule

// File: csws_properties.sv
// Port-level checks for the speed and wait-state controller.
// Assumes one clock domain and the block's synchronous reset.
`include "csws_regs.svh"
module csws_properties #(
  parameter int CHAIN = `CSWS_WS_CHAIN
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Speed
  input wire logic config_switch_bank_i,
  input wire logic rear_speed_switch_i,
  input wire logic cpu_fast_o,
  input wire logic external_freq_input_o,
  // Bus command
  input wire logic ready_n_o,
  input wire logic command_terminate_o,
  input wire logic mem_rd_n_o,
  input wire logic mem_wr_n_o,
  input wire logic io_rd_n_o,
  input wire logic io_wr_n_o,
  input wire logic interrupt_acknowledge_n_o,
  input wire logic data_enable_strobe_o
);
  logic [4:0] act;
  assign act = ~{mem_rd_n_o, mem_wr_n_o, io_rd_n_o, io_wr_n_o, interrupt_acknowledge_n_o};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i != 8'h00
    && wb_adr_i != 8'h04 |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_crystal_slow: assert property (config_switch_bank_i [*5] |->
    !cpu_fast_o && !external_freq_input_o) else $error("crystal not slow");
  a_osc_fast: assert property ((!config_switch_bank_i && rear_speed_switch_i) [*5] |->
    cpu_fast_o && external_freq_input_o) else $error("oscillator not fast");
  a_strobe_onehot: assert property ($onehot0(act))
    else $error("two strobes at once");
  a_enable_match: assert property (data_enable_strobe_o == (act != 5'h00))
    else $error("data enable not with strobe");
  a_term_ready: assert property (command_terminate_o |-> ##[0:1] !ready_n_o)
    else $error("terminate without ready");
  a_ready_hold: assert property ($fell(ready_n_o) |-> !ready_n_o [*8])
    else $error("ready too short");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_term: cover property (command_terminate_o);
  c_interrupt_acknowledge: cover property (!interrupt_acknowledge_n_o);
endmodule

bind csws_top csws_properties #(.CHAIN(CHAIN)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .config_switch_bank_i(config_switch_bank_i), .rear_speed_switch_i(rear_speed_switch_i),
  .cpu_fast_o(cpu_fast_o), .external_freq_input_o(external_freq_input_o),
  .ready_n_o(ready_n_o), .command_terminate_o(command_terminate_o),
  .mem_rd_n_o(mem_rd_n_o), .mem_wr_n_o(mem_wr_n_o), .io_rd_n_o(io_rd_n_o),
  .io_wr_n_o(io_wr_n_o), .interrupt_acknowledge_n_o(interrupt_acknowledge_n_o),
  .data_enable_strobe_o(data_enable_strobe_o)
);

// File: csws_cpu_model.sv
// Behavioural processor side: status, target attributes and command delay.
// Assumes the controller ends every started cycle with active-low ready.
module csws_cpu_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench control
  input wire logic start_i,
  input wire logic [1:0] status_i,
  input wire logic [3:0] attr_i,
  input wire logic delay_i,
  output logic done_o,
  // Controller side
  input wire logic ready_n_i,
  output logic cpu_status_bit_high_o,
  output logic cpu_status_bit_low_o,
  output logic [3:0] attr_o,
  output logic command_delay_o
);
  logic busy_q;
  logic [5:0] dly_q;
  assign command_delay_o = dly_q != 6'h00;
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      busy_q <= 1'b0;
      dly_q <= 6'h00;
      {cpu_status_bit_high_o, cpu_status_bit_low_o} <= 2'h3;
      attr_o <= 4'h0;
    end else if (!busy_q) begin
      // Unqualified lines keep changing so no stale value can pass for a real one.
      attr_o <= ~attr_o;
      if (start_i) begin
        busy_q <= 1'b1;
        {cpu_status_bit_high_o, cpu_status_bit_low_o} <= status_i;
        attr_o <= attr_i;
        dly_q <= delay_i ? 6'h28 : 6'h00;
      end
    end else begin
      if (dly_q != 6'h00) dly_q <= dly_q - 6'h01;
      if (!ready_n_i) begin
        busy_q <= 1'b0;
        {cpu_status_bit_high_o, cpu_status_bit_low_o} <= 2'h3;
        done_o <= 1'b1;
      end
    end
  end
endmodule

// File: csws_tb_top.sv
// Self-checking bench for the speed and wait-state controller.
// Assumes the processor model and the checker are compiled with it.
`include "csws_regs.svh"
module csws_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, cfg = 0, rear = 1, pgood = 0, hold = 0;
  logic start = 0, dly = 0, ack, done, sh, sl, cdly, fast, external_freq_input, cpu_rst, npx_rst, rdy_n, hold_acknowledge;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0, attr = 0, attr_o;
  logic [1:0] st = 2'h3;
  logic [2:0] obw;
  logic [4:0] seen = 0;
  wire [4:0] stb_n;
  logic [31:0] dat = 0, rdat, rd, r;
  int seed, mismatches = 0, compares = 0, cycles = 0;
  int per, act_clks = 0;
  logic ale, sck_n, mio_sel, fst, ale_seen = 0;
  csws_top dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .config_switch_bank_i(cfg), .rear_speed_switch_i(rear), .power_good_i(pgood),
    .cpu_status_bit_low_i(sl), .cpu_status_bit_high_i(sh), .mem_io_i(attr_o[3]),
    .on_board_i(attr_o[2]), .width16_i(attr_o[1]), .zero_wait_request_n_i(attr_o[0]),
    .command_delay_i(cdly), .hold_request_i(hold), .external_freq_input_o(external_freq_input),
    .cpu_fast_o(fast), .system_clock_n_o(sck_n), .cpu_reset_o(cpu_rst), .npx_reset_o(npx_rst),
    .ready_n_o(rdy_n), .command_terminate_o(), .ale_o(ale), .mem_rd_n_o(stb_n[4]),
    .mem_wr_n_o(stb_n[3]), .io_rd_n_o(stb_n[2]), .io_wr_n_o(stb_n[1]),
    .interrupt_acknowledge_n_o(stb_n[0]), .data_enable_strobe_o(), .mem_io_sel_o(mio_sel),
    .hold_acknowledge_o(hold_acknowledge)
  );
  csws_cpu_model cpu_u (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(start), .status_i(st), .attr_i(attr),
    .delay_i(dly), .done_o(done), .ready_n_i(rdy_n), .cpu_status_bit_high_o(sh),
    .cpu_status_bit_low_o(sl), .attr_o(attr_o), .command_delay_o(cdly)
  );
  // ---------------------------------------------------------------
  // Expectations and bus tasks
  // ---------------------------------------------------------------
  // Attributes are {memory, on-board, 16-bit, zero-wait low}.
  function automatic logic [3:0] exp_ws(input logic f, input logic [3:0] a, input logic [2:0] o);
    if (a[2]) return a[3] ? 4'h1 : (o == 3'h0) ? 4'h1 : (o > 3'h4) ? 4'h4 : {1'b0, o};
    if (a[3] && !a[0]) return 4'h0;
    if (!f) return a[1] ? 4'h1 : 4'h4;
    if (a[1]) return a[3] ? 4'h1 : 4'h2;
    return a[3] ? 4'h6 : 4'h4;
  endfunction
  function automatic logic [4:0] exp_stb(input logic [1:0] s, input logic m);
    if (s == 2'h0) return 5'h01;
    return m ? (s == 2'h1 ? 5'h10 : 5'h08) : (s == 2'h1 ? 5'h04 : 5'h02);
  endfunction
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rd = rdat;
    cyc <= 1'b0;
  endtask
  initial forever #4 clk_i = ~clk_i;
  // The launch edge clears the strobe record so each cycle is judged alone.
  always @(posedge clk_i) begin
    seen <= start ? 5'h00 : seen | ~stb_n;
    ale_seen <= start ? 1'b0 : ale_seen | ale;
    act_clks <= start ? 0 : act_clks + int'(stb_n != 5'h1F);
    cycles++;
    if (cycles == 50000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    seed = 12476;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check("reset pair", 32'h3, {npx_rst, cpu_rst});
    pgood <= 1'b1;
    repeat (30) @(posedge clk_i);
    check("reset pair", 32'h0, {npx_rst, cpu_rst});
    check("speed", 32'h3, {external_freq_input, fast});
    wb(1'b0, `CSWS_CTRL_OFF, 32'h0, 4'hF);
    check("ctrl", 32'h10, rd);
    wb(1'b1, 8'h08, 32'hFF, 4'hF);
    wb(1'b0, 8'h08, 32'h0, 4'hF);
    check("unmapped", 32'h0, rd);
    for (int b = 0; b < 2; b++) begin
      wb(1'b1, `CSWS_CTRL_OFF, 32'h10 | (32'h1 << b), 4'hE);
      repeat (4) @(posedge clk_i);
      check("sel gate", 32'h0, {npx_rst, cpu_rst});
      wb(1'b1, `CSWS_CTRL_OFF, 32'h10 | (32'h1 << b), 4'h1);
      repeat (3) @(posedge clk_i);
      check("soft reset", 32'h1 << b, {npx_rst, cpu_rst});
      repeat (25) @(posedge clk_i);
      check("soft reset", 32'h0, {npx_rst, cpu_rst});
    end
    for (int s = 0; s < 4; s++) begin
      {cfg, rear} <= s[1:0];
      repeat (10) @(posedge clk_i);
      check("speed", (s == 1) ? 32'h3 : 32'h0, {external_freq_input, fast});
    end
    // Count one full system clock period from a falling edge of the pin.
    while (sck_n !== 1'b1) @(posedge clk_i);
    while (sck_n !== 1'b0) @(posedge clk_i);
    per = 0;
    while (sck_n !== 1'b1) begin
      @(posedge clk_i);
      per++;
    end
    while (sck_n !== 1'b0) begin
      @(posedge clk_i);
      per++;
    end
    check("clock period", `CSWS_CLK_MHZ / `CSWS_SLOW_MHZ, per);
    for (int n = 0; n < 40; n++) begin
      r = $random(seed);
      obw = (n < 8) ? n[2:0] : r[2:0];
      attr = r[7:4];
      st = (n % 5 == 4) ? 2'h0 : {r[8], ~r[8]};
      if (st == 2'h0) attr[3] = 1'b0;
      cfg <= r[9];
      rear <= r[10];
      wb(1'b1, `CSWS_CTRL_OFF, {27'h0, obw, 2'h0}, 4'h1);
      repeat (10) @(posedge clk_i);
      while (rdy_n !== 1'b1) @(posedge clk_i);
      dly <= r[11];
      start <= 1'b1;
      @(posedge clk_i);
      start <= 1'b0;
      while (done !== 1'b1) @(posedge clk_i);
      check("strobe", exp_stb(st, attr[3]), seen);
      check("ale", 32'h1, ale_seen);
      check("mem select", attr[3], mio_sel);
      // The command runs one system clock plus one per wait, less the terminate clock.
      fst = !r[9] && r[10];
      per = fst ? `CSWS_CLK_MHZ / `CSWS_FAST_MHZ : `CSWS_CLK_MHZ / `CSWS_SLOW_MHZ;
      check("wait clocks", (exp_ws(fst, attr, obw) + 1) * per - 1, act_clks);
      if (st != 2'h0) begin
        wb(1'b0, `CSWS_STAT_OFF, 32'h0, 4'hF);
        check("waits", exp_ws(!r[9] && r[10], attr, obw), rd[11:8]);
      end
    end
    hold <= 1'b1;
    while (hold_acknowledge !== 1'b1) @(posedge clk_i);
    wb(1'b0, `CSWS_STAT_OFF, 32'h0, 4'hF);
    check("hold", 32'h10, rd & 32'h10);
    check("idle strobes", 32'h1F, stb_n);
    hold <= 1'b0;
    {cfg, rear} <= 2'h1;
    repeat (10) @(posedge clk_i);
    // At the fast rate the stretch outlasts a system clock, so shutdown holds reset.
    st = 2'h0;
    attr = 4'h8;
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    repeat (40) @(posedge clk_i);
    check("shutdown", 32'h1, {npx_rst, cpu_rst});
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("reset pair", 32'h3, {npx_rst, cpu_rst});
    check("ready idle", 32'h1, rdy_n);
    repeat (25) @(posedge clk_i);
    check("reset pair", 32'h0, {npx_rst, cpu_rst});
    stop_test();
  end
endmodule
